// ==== bench/fracn_asserts.sv ====
// Checker for output relations of the control core
`timescale 1ns/10ps
`default_nettype none
module fracn_asserts (
  // Clock, reset, strobe and outputs
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load_strobe,
  input wire logic [9:0] n_divide,
  input wire logic [11:0] fraction_denominator,
  input wire logic [11:0] active_seed,
  input wire logic detector_sense,
  input wire logic pump_output_grounded,
  input wire logic [4:0] powerdown_bits,
  input wire logic synth_powered,
  input wire logic channel_valid,
  input wire logic dither_on,
  input wire logic [8:0] pump_current_timer
);
  // ==================================================
  // Cycles since strobe seen high; function, shadow, dither and pump timer outputs may only move shortly after
  logic [3:0] since;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      since <= 4'hf;
    end else if (load_strobe) begin
      since <= 4'h0;
    end else if (since != 4'hf) begin
      since <= since + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_den_min: assert property (fraction_denominator >= 12'h00d)
    else $error("denominator below range");
  a_ndiv_span: assert property (channel_valid && $stable(fraction_denominator)
    |-> (n_divide - $past(n_divide) + 10'h007) <= 10'h00e) else $error("divide step too big");
  a_func_cause: assert property ($changed(detector_sense)
    || $changed(pump_output_grounded) |-> since <= 4'h8) else $error("function moved alone");
  a_shadow_hold: assert property ($changed(fraction_denominator)
    || $changed(active_seed) |-> since <= 4'h8) else $error("shadow moved alone");
  a_mode_cause: assert property ($changed(dither_on) |-> since <= 4'h8)
    else $error("dither moved alone");
  a_timer_cause: assert property ($changed(pump_current_timer) |-> since <= 4'h8)
    else $error("timer moved alone");
  a_pwr_clear: assert property (synth_powered |-> powerdown_bits == 5'h00)
    else $error("powered with bits set");
  a_valid_late: assert property ($rose(channel_valid) |-> $past(synth_powered))
    else $error("valid before power");
  c_pwr: cover property ($rose(synth_powered));
  c_valid: cover property ($rose(channel_valid));
  c_dither: cover property ($rose(dither_on));
endmodule : fracn_asserts
bind fracn_modulator_init_control fracn_asserts u_chk (.*);
`default_nettype wire

// ==== bench/host_model.sv ====
// Host model: writes serial words to the control core
`timescale 1ns/10ps
`default_nettype none
module host_model
  import fracn_pkg::*;
#(
  // Pump discharge wait, shortened from 10 ms
  parameter int WAIT_NS = 2000
) (
  // Link pins
  output logic link_clk,
  output logic sdata,
  output logic load_strobe
);
  // ==================================================
  // Power-up words in order
  serial_word_t seq [14] = '{
    24'h0000fd, 24'h00005b,
    24'h000007, 24'h00000e, 24'h00900e,
    24'h004464, 24'h00446c, 24'h004394,
    24'h0000d2, 24'h520209, 24'h480140,
    24'h00007b, 24'h000005, 24'h480140
  };
  initial begin
    link_clk = 1'b0;
    sdata = 1'b0;
    load_strobe = 1'b0;
  end
  // Clock stands low between frames; idle data shows the inverse bit
  task automatic send(input serial_word_t w);
    for (int i = 23; i >= 0; i--) begin
      sdata = w[i];
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
    end
    sdata = ~w[0];
    #8 load_strobe = 1'b1;
    #40 load_strobe = 1'b0;
    #40;
  endtask : send
  task automatic step(input int k);
    send(seq[k]);
    if (k == 1) #(WAIT_NS);
  endtask : step
endmodule : host_model
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the fractional-N control core
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fracn_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic lclk, sd, le;
  logic [9:0] ndiv;
  logic [11:0] den, seed;
  logic [4:0] pd;
  logic [20:0] test;
  logic [8:0] t3, tr, tp;
  logic sense, gnd, pwr, valid, dith, ld10;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int id;
  int q_id[$];
  logic [31:0] q_exp[$];
  logic [31:0] sum, rnd, e, g;
  event chk;
  string nm [6] = '{"status", "mode", "timers", "den_seed", "test", "sum"};
  int tbl [4][3] = '{'{13, 5, 13}, '{64, 9, 128}, '{66, 11, 396}, '{4095, 7, 12285}};
  always #4 ref_clk = ~ref_clk;
  host_model u_host (.link_clk(lclk), .sdata(sd), .load_strobe(le));
  fracn_modulator_init_control u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(lclk),
    .sdata(sd), .load_strobe(le), .n_divide(ndiv), .fraction_denominator(den),
    .active_seed(seed), .detector_sense(sense), .pump_output_grounded(gnd),
    .powerdown_bits(pd), .synth_powered(pwr), .channel_valid(valid), .dither_on(dith),
    .lock_threshold_10ns(ld10), .test_mode_bits(test), .third_switch_timer(t3),
    .loop_resistor_switch_timer(tr), .pump_current_timer(tp));
  // ==================================================
  // Notes queue and watcher
  function automatic logic [31:0] seen(input int k);
    case (k)
      0: return {23'h0, pd, gnd, sense, pwr, valid};
      1: return {30'h0, dith, ld10};
      2: return {5'h0, t3, tr, tp};
      3: return {8'h0, den, seed};
      4: return {11'h0, test};
      default: return sum;
    endcase
  endfunction : seen
  task automatic note(input int k, input logic [31:0] v);
    q_id.push_back(k);
    q_exp.push_back(v);
    -> chk;
  endtask : note
  always @(chk) begin
    while (q_id.size() > 0) begin
      id = q_id.pop_front();
      e = q_exp.pop_front();
      g = seen(id);
      tests_run++;
      if (g !== e) begin
        err_count++;
        $display("unexpected %s: expected %h seen %h", nm[id], e, g);
      end
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic put(input serial_word_t w);
    u_host.send(w);
    repeat (8) @(posedge ref_clk);
  endtask : put
  // Over one full repeat the divide values add up to L*int + partial_step_count*L/den
  task automatic sum_run(input int len);
    sum = 32'h0;
    repeat (len) begin
      @(posedge ref_clk);
      #1 sum += 32'(ndiv);
    end
  endtask : sum_run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    note(0, 32'h1f8);
    note(3, 32'h00d000);
    rst_n <= 1'b1;
    for (int k = 0; k < 14; k++) begin
      u_host.step(k);
      repeat (8) @(posedge ref_clk);
      case (k)
        0: note(0, 32'h1f8);
        1: note(0, 32'h1fc);
        2: note(4, 32'h0);
        3: note(1, 32'h0);
        4: note(1, 32'h1);
        7: note(2, {5'h0, 9'd35, 9'd35, 9'd28});
        9: note(3, 32'h00d000);
        10: note(3, {8'h0, 12'd65, 12'd26});
        11: note(0, 32'h1f4);
        12: note(0, 32'h006);
        13: note(0, 32'h007);
        default: ;
      endcase
    end
    $display("test init done");
    rnd = 32'hb4e4;
    repeat (3) begin
      rnd = lfsr(rnd);
      put({1'b0, 8'd144, 12'(rnd % 65), 3'h0});
      sum_run(65);
      note(5, 32'd9360 + rnd % 65);
    end
    foreach (tbl[i]) begin
      put({9'h0a4, 12'(tbl[i][0]), 3'h1});
      put({1'b0, 8'd144, 12'(tbl[i][1]), 3'h0});
      note(3, {8'h0, 12'(tbl[i][0]), 12'd26});
      sum_run(tbl[i][2]);
      note(5, 32'(tbl[i][2] * 144 + tbl[i][1] * tbl[i][2] / tbl[i][0]));
    end
    $display("test modulator done");
    put(24'h00300e);
    note(1, 32'h3);
    put(24'h00500e);
    note(1, 32'h3);
    put(24'h00000e);
    note(1, 32'h0);
    $display("test modes done");
    repeat (4) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

// ==== hdl/fracn_modulator_init_control.sv ====
// Control core: serial register decode and third-order noise-shaping modulator
`timescale 1ns/10ps
`default_nettype none
`include "fracn_consts.svh"
module fracn_modulator_init_control
  import fracn_pkg::*;
(
  // Reference clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial link
  input wire logic link_clk,
  input wire logic sdata,
  input wire logic load_strobe,
  // Divider control
  output logic [9:0] n_divide,
  output logic [11:0] fraction_denominator,
  output logic [11:0] active_seed,
  // Analog control levels
  output logic detector_sense,
  output logic pump_output_grounded,
  output logic [4:0] powerdown_bits,
  output logic synth_powered,
  output logic channel_valid,
  output logic dither_on,
  output logic lock_threshold_10ns,
  output logic [20:0] test_mode_bits,
  // Timers
  output logic [8:0] third_switch_timer,
  output logic [8:0] loop_resistor_switch_timer,
  output logic [8:0] pump_current_timer
);
  shift_link_if link ();

  serial_word_capture u_capture (
    .link_clk(link_clk),
    .sdata(sdata),
    .link(link.capture)
  );

  // =====================================================================
  // Strobe synchroniser and edge detect
  logic strobe_meta;
  logic strobe_sync;
  logic strobe_last;
  always_ff @(posedge ref_clk) begin
    strobe_meta <= load_strobe;
    strobe_sync <= strobe_meta;
    strobe_last <= strobe_sync;
  end

  // The word is quasi-static here: no link edges occur while the strobe is high
  wire load_now = strobe_sync & ~strobe_last;
  wire serial_word_t word = link.word;
  wire dest_sel_t dest = word[`SEL_HI:`SEL_LO];
  wire wr_freq = load_now && (dest == `SEL_FREQ);
  wire wr_div = load_now && (dest == `SEL_DIV);
  wire wr_phase = load_now && (dest == `SEL_PHASE);
  wire wr_func = load_now && (dest == `SEL_FUNC);
  wire wr_timeout = load_now && (dest == `SEL_TIMEOUT);
  wire wr_pwrdn = load_now && (dest == `SEL_PWRDN);
  wire wr_mode = load_now && (dest == `SEL_MODE);
  wire wr_test = load_now && (dest == `SEL_TEST);
  wire [3:0] mode_nib = word[`MODE_HI:`MODE_LO];
  wire [1:0] tsel = word[`TSEL_HI:`TSEL_LO];
  wire [8:0] tval = word[`TVAL_HI:`TVAL_LO];

  // =====================================================================
  // Shadow stage and configuration registers
  den_t div_shadow;
  logic [11:0] seed_shadow;
  logic seen_div;
  logic seen_phase;
  logic seen_freq;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_shadow <= `DEN_RESET;
      seed_shadow <= 12'h000;
      seen_div <= 1'b0;
      seen_phase <= 1'b0;
    end else begin
      if (wr_div) begin
        div_shadow <= word[`DEN_HI:`DEN_LO];
        seen_div <= 1'b1;
      end
      if (wr_phase) begin
        seed_shadow <= word[`SEED_HI:`SEED_LO];
        seen_phase <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      detector_sense <= 1'b0;
      pump_output_grounded <= 1'b1;
      powerdown_bits <= 5'h1f;
      test_mode_bits <= 21'h000000;
      third_switch_timer <= 9'h000;
      loop_resistor_switch_timer <= 9'h000;
      pump_current_timer <= 9'h000;
    end else begin
      if (wr_func) begin
        detector_sense <= word[`FUNC_SENSE_BIT];
        pump_output_grounded <= ~word[`FUNC_GND_BIT];
      end
      if (wr_pwrdn) begin
        powerdown_bits <= word[`PD_HI:`PD_LO];
      end
      if (wr_test) begin
        test_mode_bits <= word[23:3];
      end
      if (wr_timeout && tsel == 2'h0) begin
        third_switch_timer <= tval;
      end
      if (wr_timeout && tsel == 2'h1) begin
        loop_resistor_switch_timer <= tval;
      end
      if (wr_timeout && tsel == 2'h2) begin
        pump_current_timer <= tval;
      end
    end
  end

  // Unlisted nibbles leave both settings as they were
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dither_on <= 1'b0;
      lock_threshold_10ns <= 1'b0;
    end else if (wr_mode) begin
      if (mode_nib == `MODE_DEFAULT) begin
        dither_on <= 1'b0;
        lock_threshold_10ns <= 1'b0;
      end else if (mode_nib == `MODE_DITHER) begin
        dither_on <= 1'b1;
      end else if (mode_nib == `MODE_LD10) begin
        lock_threshold_10ns <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Power state and channel activation
  // Leaving power-down needs clear bits plus divider, seed and frequency writes.
  wire pd_clear = (powerdown_bits == 5'h00);
  wire next_powered = pd_clear && seen_div && seen_phase && seen_freq;
  logic [7:0] int_part;
  logic [11:0] partial_step_count_part;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seen_freq <= 1'b0;
      synth_powered <= 1'b0;
      channel_valid <= 1'b0;
      int_part <= 8'h00;
      partial_step_count_part <= 12'h000;
      fraction_denominator <= `DEN_RESET;
      active_seed <= 12'h000;
    end else begin
      synth_powered <= next_powered;
      if (wr_freq) begin
        seen_freq <= 1'b1;
        int_part <= word[`INT_HI:`INT_LO];
        partial_step_count_part <= word[`PARTIAL_STEP_COUNT_HI:`PARTIAL_STEP_COUNT_LO];
        fraction_denominator <= div_shadow;
        active_seed <= seed_shadow;
      end
      if (!next_powered) begin
        channel_valid <= 1'b0;
      end else if (wr_freq) begin
        channel_valid <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Third-order noise-shaping modulator, three cascaded modulo stages
  // Any denominator from 13 to 4095 works if the inputs are below it; nothing clamps them.
  logic [11:0] acc1;
  logic [11:0] acc2;
  logic [11:0] acc3;
  logic c2d;
  logic c3d;
  logic c3dd;
  logic [20:0] lfsr;
  wire dith = dither_on & lfsr[0];
  wire [12:0] s1 = {1'b0, acc1} + {1'b0, partial_step_count_part} + {12'h000, dith};
  wire [12:0] s2 = {1'b0, acc2} + {1'b0, acc1};
  wire [12:0] s3 = {1'b0, acc3} + {1'b0, acc2};
  wire [12:0] den13 = {1'b0, fraction_denominator};
  wire c1 = (s1 >= den13);
  wire c2 = (s2 >= den13);
  wire c3 = (s3 >= den13);
  wire [12:0] r1 = c1 ? s1 - den13 : s1;
  wire [12:0] r2 = c2 ? s2 - den13 : s2;
  wire [12:0] r3 = c3 ? s3 - den13 : s3;
  // Offset = c1 + (c2 - c2d) + (c3 - 2*c3d + c3dd), range -3..+4
  wire signed [3:0] offset = $signed({3'b000, c1}) + $signed({3'b000, c2})
      - $signed({3'b000, c2d}) + $signed({3'b000, c3}) - $signed({2'b00, c3d, 1'b0})
      + $signed({3'b000, c3dd});
  wire [9:0] next_n = {2'b00, int_part} + {{6{offset[3]}}, offset};
  wire lfsr_fb = lfsr[20] ^ lfsr[18];

  // Advances every reference cycle while powered; the undithered period follows from
  // the denominator's divisibility by two and three.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || wr_freq || !synth_powered) begin
      acc1 <= wr_freq ? word[`SEED_HI:`SEED_LO] & 12'h000 | seed_shadow : 12'h000;
      acc2 <= 12'h000;
      acc3 <= 12'h000;
      c2d <= 1'b0;
      c3d <= 1'b0;
      c3dd <= 1'b0;
      n_divide <= {2'b00, int_part};
    end else begin
      acc1 <= r1[11:0];
      acc2 <= r2[11:0];
      acc3 <= r3[11:0];
      c2d <= c2;
      c3d <= c3;
      c3dd <= c3d;
      n_divide <= next_n;
    end
  end

  // Maximal-length 21-bit sequence for dither
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lfsr <= `LFSR_SEED;
    end else begin
      lfsr <= {lfsr[19:0], lfsr_fb};
    end
  end
endmodule : fracn_modulator_init_control
`default_nettype wire

// ==== hdl/serial_word_capture.sv ====
// Shift register on the link clock that assembles the serial word
`timescale 1ns/10ps
`default_nettype none
module serial_word_capture
  import fracn_pkg::*;
(
  // Link side
  input wire logic link_clk,
  input wire logic sdata,
  // Assembled word
  shift_link_if.capture link
);
  serial_word_t shift;

  // =====================================================================
  // Shift, most significant bit first
  // The link clock stops outside frames, so the word stays still while
  // the core samples it after the load strobe.
  always_ff @(posedge link_clk) begin
    shift <= {shift[22:0], sdata};
  end

  assign link.word = shift;
endmodule : serial_word_capture
`default_nettype wire

// ==== pkg/fracn_consts.svh ====
// Constants for the fractional-N control core: word layout, codes and reset values
`ifndef FRACN_CONSTS_SVH
`define FRACN_CONSTS_SVH

// =====================================================================
// Serial word layout
`define WORD_W 24
`define SEL_LO 0
`define SEL_HI 2
`define FIELD_LO 3

// =====================================================================
// Destination codes in the three low control bits
`define SEL_FREQ 3'h0
`define SEL_DIV 3'h1
`define SEL_PHASE 3'h2
`define SEL_FUNC 3'h3
`define SEL_TIMEOUT 3'h4
`define SEL_PWRDN 3'h5
`define SEL_MODE 3'h6
`define SEL_TEST 3'h7

// =====================================================================
// Field positions
`define PARTIAL_STEP_COUNT_LO 3
`define PARTIAL_STEP_COUNT_HI 14
`define INT_LO 15
`define INT_HI 22
`define DEN_LO 3
`define DEN_HI 14
`define SEED_LO 3
`define SEED_HI 14
`define FUNC_GND_BIT 5
`define FUNC_SENSE_BIT 6
`define TSEL_LO 3
`define TSEL_HI 4
`define TVAL_LO 5
`define TVAL_HI 13
`define PD_LO 3
`define PD_HI 7
`define MODE_LO 12
`define MODE_HI 15

// =====================================================================
// Mode patterns and limits
`define MODE_DEFAULT 4'h0
`define MODE_DITHER 4'h3
`define MODE_LD10 4'h9
`define DEN_MIN 12'h00d
`define DEN_RESET 12'h00d
`define LFSR_SEED 21'h000001

`endif

// ==== pkg/fracn_pkg.sv ====
// Types shared by the fractional-N control core
package fracn_pkg;
  typedef logic [23:0] serial_word_t;
  typedef logic [11:0] den_t;
  typedef logic [2:0] dest_sel_t;
endpackage : fracn_pkg

// ==== pkg/shift_link_if.sv ====
// Carrier for the assembled serial word between link and core logic
`timescale 1ns/10ps
`default_nettype none
interface shift_link_if;
  logic [23:0] word;
  modport capture (output word);
  modport consumer (input word);
endinterface : shift_link_if
`default_nettype wire
